// [dv/tb.sv]
// self-checking bench for the reset and wake-up initialiser
`timescale 1ns/1ns
`default_nettype none
module tb;
	import rwi_pkg::*;
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	logic [11:0] paddr = 12'h000;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic evt_valid = 1'b0;
	rwi_cause_t evt_cause = C_POWER_ON;
	logic [3:0] wake_src = 4'h0;
	logic wake_high = 1'b0;
	logic [7:0] port_pin = 8'h00;
	logic [7:0] first_port_latch;
	logic [7:0] first_port_direction;
	logic [PC_W-1:0] pc;
	logic init_done;
	logic [31:0] rdat;
	logic rerr;
	int mismatches = 0;
	int checks = 0;

	rwi_reset_init rwi_reset_init_inst (
		.sys_clk(sys_clk), .srst(srst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.evt_valid(evt_valid), .evt_cause(evt_cause), .wake_src(wake_src),
		.wake_high(wake_high), .port_pin(port_pin),
		.first_port_latch(first_port_latch),
		.first_port_direction(first_port_direction),
		.pc(pc), .init_done(init_done)
	);

	always #20 sys_clk = ~sys_clk;

	////////////////////////////////////////////////////////////////////
	task complete_run;
		$display("mismatches=%0d checks=%0d", mismatches, checks);
		if (mismatches == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// held until pready is sampled high, data taken at that edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			mismatches++;
			complete_run();
		end
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h00000000);
		chk(rdat, exp);
	endtask

	// one event; image must land two edges after it is sampled
	task ev(input rwi_cause_t c, input logic [3:0] s, input logic h);
		int n;
		@(posedge sys_clk);
		evt_valid <= 1'b1;
		evt_cause <= c;
		wake_src <= s;
		wake_high <= h;
		@(posedge sys_clk);
		evt_valid <= 1'b0;
		n = 0;
		while (init_done !== 1'b1 && n < 10)
		begin
			@(posedge sys_clk);
			n++;
		end
		if (init_done !== 1'b1)
		begin
			mismatches++;
			complete_run();
		end
		chk(n, 2);
	endtask

	// preload known state, fire one cause, compare the image
	task run_cause(input rwi_cause_t c, input logic [7:0] rcs,
		input logic [7:0] stk, input logic [7:0] lat, input logic [7:0] ic,
		input logic [PC_W-1:0] epc);
		wr(OFF_RCS, 32'h000000BF);
		wr(OFF_STK, 32'h00000003);
		wr(OFF_LAT, 32'h00000015);
		wr(OFF_INTC, 32'h000000C1);
		wr(OFF_PC, 32'h00000100);
		ev(c, 4'h0, 1'b0);
		chk(pc, epc);
		chk(first_port_latch, lat);
		rd(OFF_RCS, rcs);
		rd(OFF_STK, stk);
		rd(OFF_INTC, ic);
	endtask

	////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (8) @(posedge sys_clk);
		srst <= 1'b0;
		chk(first_port_direction, 8'h3F);
		chk(pc, 21'h000000);
		rd(OFF_RCS, 32'h0000003C);
		rd(OFF_STK, 32'h00000000);
		rd(OFF_DIR, 32'h0000003F);
		apb(1'b0, 12'h0FC, 32'h00000000);
		chk(rerr, 1'b1);
		chk(rdat, 32'h00000000);
		wr(OFF_TOS, 32'h00001234);
		rd(OFF_TOS, 32'h00000000);
		// unimplemented bits read zero
		wr(OFF_STK, 32'hFFFFFFFF);
		rd(OFF_STK, 32'h000000DF);
		wr(OFF_RCS, 32'hFFFFFFFF);
		rd(OFF_RCS, 32'h000000BF);
		// port bits 6 and 7 follow the oscillator mode
		port_pin <= 8'hEA;
		wr(OFF_DIR, 32'h000000FF);
		rd(OFF_DIR, 32'h0000003F);
		rd(OFF_PIN, 32'h0000002A);
		wr(OFF_CTRL, 32'h00000001);
		wr(OFF_DIR, 32'h000000FF);
		wr(OFF_LAT, 32'h000000C5);
		rd(OFF_DIR, 32'h000000FF);
		rd(OFF_PIN, 32'h000000EA);
		wr(OFF_CTRL, 32'h00000000);
		rd(OFF_LAT, 32'h00000005);
		chk(first_port_direction, 8'h3F);
		// interrupt wake, high enable
		wr(OFF_STK, 32'h00000003);
		wr(OFF_PIR, 32'h00000000);
		wr(OFF_INTC, 32'h00000080);
		wr(OFF_PC, 32'h00012345);
		ev(C_WAKE_INT, 4'h2, 1'b1);
		chk(pc, VEC_HIGH);
		rd(OFF_TOS, 32'h00012345);
		rd(OFF_STK, 32'h00000004);
		rd(OFF_PIR, 32'h00000004);
		rd(OFF_INTC, 32'h00000080);
		// interrupt wake, low enable, source in control register
		wr(OFF_INTC, 32'h00000040);
		wr(OFF_PC, 32'h00000100);
		ev(C_WAKE_INT, 4'h9, 1'b0);
		chk(pc, VEC_LOW);
		rd(OFF_TOS, 32'h00000100);
		rd(OFF_STK, 32'h00000005);
		rd(OFF_INTC, 32'h00000042);
		rd(OFF_PIR, 32'h00000004);
		// no global enable: no push, no vector
		wr(OFF_INTC, 32'h00000000);
		wr(OFF_PC, 32'h00000200);
		ev(C_WAKE_INT, 4'h0, 1'b1);
		chk(pc, 21'h000202);
		rd(OFF_TOS, 32'h00000100);
		rd(OFF_STK, 32'h00000005);
		rd(OFF_PIR, 32'h00000005);
		// every event class, and every cause except the interrupt wake
		run_cause(C_POWER_ON, 8'h3C, 8'h00, 8'h00, 8'h00, 21'h0);
		run_cause(C_BROWN_OUT, 8'h3E, 8'h00, 8'h00, 8'h00, 21'h0);
		run_cause(C_PIN_RUN, 8'h3F, 8'h00, 8'h15, 8'h01, 21'h0);
		run_cause(C_PIN_SLEEP, 8'h3B, 8'h00, 8'h15, 8'h01, 21'h0);
		run_cause(C_WDT_RUN, 8'h37, 8'h00, 8'h15, 8'h01, 21'h0);
		run_cause(C_SOFT_RESET, 8'h2F, 8'h00, 8'h15, 8'h01, 21'h0);
		run_cause(C_STACK_FULL, 8'h3F, 8'h80, 8'h15, 8'h01, 21'h0);
		run_cause(C_STACK_UNDER, 8'h3F, 8'h40, 8'h15, 8'h01, 21'h0);
		run_cause(C_MONITOR, 8'h1F, 8'h00, 8'h15, 8'h01, 21'h0);
		run_cause(C_WAKE_WDT, 8'hB3, 8'h03, 8'h15, 8'hC1, 21'h102);
		// a latch write landing on the edge of a watchdog wake is lost
		fork
			wr(OFF_LAT, 32'h0000002A);
			begin
				repeat (2) @(posedge sys_clk);
				evt_valid <= 1'b1;
				evt_cause <= C_WAKE_WDT;
				@(posedge sys_clk);
				evt_valid <= 1'b0;
			end
		join
		rd(OFF_LAT, 32'h00000015);
		chk(pc, 21'h000104);
		complete_run();
	end

	initial
	begin
		#3000000;
		mismatches++;
		complete_run();
	end
endmodule
`default_nettype wire

// [hw/rwi_event_class.sv]
// registers an incoming event and sorts it into its class
`timescale 1ns/1ns
`default_nettype none
module rwi_event_class (
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// raw event
	input wire logic evt_valid,
	input wire rwi_pkg::rwi_cause_t evt_cause,
	input wire logic [3:0] wake_src,
	input wire logic wake_high,
	// classified event
	output logic cls_valid,
	output rwi_pkg::rwi_class_t cls_class,
	output rwi_pkg::rwi_cause_t cls_cause,
	output logic [3:0] cls_src,
	output logic cls_high
);
	import rwi_pkg::*;

	logic next_valid;
	rwi_class_t next_class;
	rwi_cause_t next_cause;
	logic [3:0] next_src;
	logic next_high;

	always_comb
	begin
		next_valid = evt_valid;
		next_class = rwi_class_of(evt_cause); // RULE9
		next_cause = evt_cause;
		next_src = wake_src;
		next_high = wake_high;
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			cls_valid <= 1'b0;
			cls_class <= CLS_POR;
			cls_cause <= C_POWER_ON;
			cls_src <= 4'h0;
			cls_high <= 1'b0;
		end
		else
		begin
			cls_valid <= next_valid;
			cls_class <= next_class;
			cls_cause <= next_cause;
			cls_src <= next_src;
			cls_high <= next_high;
		end
	end
endmodule
`default_nettype wire

// [hw/rwi_pkg.sv]
// constants, types and helpers for the reset and wake-up initialiser
// Overview of operation
// RULE1 - interrupt wake with a global enable copies the program counter to top-of-stack
// RULE2 - that same wake advances the return stack pointer by one location
// RULE3 - that wake loads the program counter with vector 0008h or 0018h
// RULE4 - interrupt wake sets the source flag; other flag bits stay unchanged
// RULE5 - first port bits 6 and 7 exist only when oscillator mode frees them
// RULE6 - unimplemented bits always read zero after any reset or wake
// RULE7 - bits marked unchanged keep their contents through the event
// RULE8 - reset cause status bits take values chosen by the exact event
// RULE9 - events fall into three classes, each with its own register image
`default_nettype none
package rwi_pkg;
	localparam int PC_W = 21;
	// apb byte offsets
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_PC = 12'h004;
	localparam logic [11:0] OFF_TOS = 12'h008;
	localparam logic [11:0] OFF_STK = 12'h00C;
	localparam logic [11:0] OFF_INTC = 12'h010;
	localparam logic [11:0] OFF_PIR = 12'h014;
	localparam logic [11:0] OFF_PIN = 12'h018;
	localparam logic [11:0] OFF_LAT = 12'h01C;
	localparam logic [11:0] OFF_DIR = 12'h020;
	localparam logic [11:0] OFF_RCS = 12'h024;
	localparam logic [3:0] IDX_NONE = 4'hF;
	// fields
	localparam int INTC_GIE_HI = 7;
	localparam int INTC_GIE_LO = 6;
	localparam int STK_FULL = 7;
	localparam int STK_UNDER = 6;
	localparam int RCS_PRIO_EN = 7;
	localparam int RCS_MON_N = 5;
	localparam int RCS_SOFT_N = 4;
	localparam int RCS_TO_N = 3;
	localparam int RCS_PD_N = 2;
	localparam int RCS_POR_N = 1;
	localparam int RCS_BOR_N = 0;
	localparam logic [7:0] STK_IMPL = 8'hDF;
	localparam logic [7:0] RCS_IMPL = 8'hBF;
	localparam logic [7:0] PORT_ALL = 8'hFF;
	localparam logic [7:0] PORT_LOW6 = 8'h3F;
	localparam logic [4:0] PTR_MAX = 5'h1F;
	// reset images
	localparam logic [PC_W-1:0] PC_RST = 21'h000000;
	localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
	localparam logic [PC_W-1:0] VEC_HIGH = 21'h000008;
	localparam logic [PC_W-1:0] VEC_LOW = 21'h000018;
	localparam logic [7:0] INTC_RST = 8'h00;
	localparam logic [7:0] PIR_RST = 8'h00;
	localparam logic [7:0] LAT_POR = 8'h00;
	localparam logic [7:0] DIR_RST = 8'hFF;
	localparam logic [7:0] RCS_POR = 8'h3C;
	localparam logic [7:0] RCS_BOR = 8'h3E;

	typedef enum logic [1:0] {
		CLS_POR = 2'b00,
		CLS_RST = 2'b01,
		CLS_WAKE = 2'b10
	} rwi_class_t;

	typedef enum logic [3:0] {
		C_POWER_ON = 4'h0,
		C_BROWN_OUT = 4'h1,
		C_PIN_RUN = 4'h2,
		C_PIN_SLEEP = 4'h3,
		C_WDT_RUN = 4'h4,
		C_SOFT_RESET = 4'h5,
		C_STACK_FULL = 4'h6,
		C_STACK_UNDER = 4'h7,
		C_MONITOR = 4'h8,
		C_WAKE_WDT = 4'h9,
		C_WAKE_INT = 4'hA
	} rwi_cause_t;

	function automatic rwi_class_t rwi_class_of(input rwi_cause_t c);
		case (c)
			C_POWER_ON, C_BROWN_OUT: return CLS_POR;
			C_WAKE_WDT, C_WAKE_INT: return CLS_WAKE;
			default: return CLS_RST;
		endcase
	endfunction
endpackage
`default_nettype wire

// [hw/rwi_reset_init.sv]
// reset and wake-up register initialiser with apb register access
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module rwi_reset_init (
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// apb slave
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// event from the reset and wake detectors
	input wire logic evt_valid,
	input wire rwi_pkg::rwi_cause_t evt_cause,
	input wire logic [3:0] wake_src,
	input wire logic wake_high,
	// first port pins
	input wire logic [7:0] port_pin,
	output logic [7:0] first_port_latch,
	output logic [7:0] first_port_direction,
	// core view
	output logic [rwi_pkg::PC_W-1:0] pc,
	output logic init_done
);
	import rwi_pkg::*;

	function automatic logic [3:0] reg_sel(input logic [11:0] a);
		case (a)
			OFF_CTRL: return 4'h0;
			OFF_PC: return 4'h1;
			OFF_TOS: return 4'h2;
			OFF_STK: return 4'h3;
			OFF_INTC: return 4'h4;
			OFF_PIR: return 4'h5;
			OFF_PIN: return 4'h6;
			OFF_LAT: return 4'h7;
			OFF_DIR: return 4'h8;
			OFF_RCS: return 4'h9;
			default: return IDX_NONE;
		endcase
	endfunction

	logic cls_valid;
	rwi_class_t cls_class;
	rwi_cause_t cls_cause;
	logic [3:0] cls_src;
	logic cls_high;

	rwi_event_class u_class (
		.sys_clk(sys_clk),
		.srst(srst),
		.evt_valid(evt_valid),
		.evt_cause(evt_cause),
		.wake_src(wake_src),
		.wake_high(wake_high),
		.cls_valid(cls_valid),
		.cls_class(cls_class),
		.cls_cause(cls_cause),
		.cls_src(cls_src),
		.cls_high(cls_high)
	);

	////////////////////////////////////////////////////////////////////////
	// pin synchroniser
	logic [7:0] pin_meta;
	logic [7:0] pin_sync;

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			pin_meta <= 8'h00;
			pin_sync <= 8'h00;
		end
		else
		begin
			pin_meta <= port_pin;
			pin_sync <= pin_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// apb handshake
	logic [3:0] idx;
	logic acc;
	logic wr;
	logic [31:0] rd_val;
	logic next_pready;
	logic next_pslverr;
	logic [31:0] next_prdata;

	logic osc_frees;
	logic [PC_W-1:0] tos;
	logic [7:0] return_stack_pointer;
	logic [7:0] interrupt_control_regs;
	logic [7:0] peripheral_request_flags;
	logic [7:0] first_port_input;
	logic [7:0] reset_cause_status;

	always_comb
	begin
		idx = reg_sel(paddr);
		acc = psel & penable;
		// one wait state; effect only on the sampled edge
		wr = acc & pready & pwrite & (idx != IDX_NONE);
		case (idx)
			4'h0: rd_val = {31'h0, osc_frees};
			4'h1: rd_val = {11'h0, pc};
			4'h2: rd_val = {11'h0, tos};
			4'h3: rd_val = {24'h0, return_stack_pointer};
			4'h4: rd_val = {24'h0, interrupt_control_regs};
			4'h5: rd_val = {24'h0, peripheral_request_flags};
			4'h6: rd_val = {24'h0, first_port_input};
			4'h7: rd_val = {24'h0, first_port_latch};
			4'h8: rd_val = {24'h0, first_port_direction};
			4'h9: rd_val = {24'h0, reset_cause_status};
			default: rd_val = 32'h0;
		endcase
		next_pready = acc & ~pready;
		next_pslverr = acc & ~pready & (idx == IDX_NONE);
		next_prdata = (acc & ~pready & ~pwrite) ? rd_val : 32'h0;
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end
		else
		begin
			pready <= next_pready;
			pslverr <= next_pslverr;
			prdata <= next_prdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// special-function register images
	logic next_osc;
	logic [7:0] port_mask;
	logic [PC_W-1:0] next_pc;
	logic [PC_W-1:0] next_tos;
	logic [7:0] next_stk;
	logic [7:0] next_intc;
	logic [7:0] next_pir;
	logic [7:0] next_pin;
	logic [7:0] next_lat;
	logic [7:0] next_dir;
	logic [7:0] next_rcs;
	logic next_done;
	logic gie_any;
	logic [11:0] src_onehot;

	always_comb
	begin
		next_osc = osc_frees;
		if (wr && idx == 4'h0)
			next_osc = pwdata[0];
		port_mask = next_osc ? PORT_ALL : PORT_LOW6;
		gie_any = interrupt_control_regs[INTC_GIE_HI]
			| interrupt_control_regs[INTC_GIE_LO];
		// pir bits 0-7, then interrupt control bits 0-3
		src_onehot = cls_src[3] ? (12'h100 << cls_src[1:0])
			: (12'h001 << cls_src[2:0]);
		next_pc = pc;
		next_tos = tos;
		next_stk = return_stack_pointer;
		next_intc = interrupt_control_regs;
		next_pir = peripheral_request_flags;
		next_lat = first_port_latch;
		next_dir = first_port_direction;
		next_rcs = reset_cause_status;
		next_pin = pin_sync;
		next_done = cls_valid;
		if (wr && !cls_valid)
		begin
			case (idx)
				4'h1: next_pc = pwdata[PC_W-1:0];
				4'h3: next_stk = pwdata[7:0];
				4'h4: next_intc = pwdata[7:0];
				4'h5: next_pir = pwdata[7:0];
				4'h7: next_lat = pwdata[7:0];
				4'h8: next_dir = pwdata[7:0];
				4'h9: next_rcs = pwdata[7:0];
				default: next_pc = pc;
			endcase
		end
		// a hardware event wins over a register write in the same cycle, except a write to the control register (osc_frees)
		if (cls_valid)
		begin
			case (cls_class) // RULE9
				CLS_POR:
				begin
					next_pc = PC_RST;
					next_tos = PC_RST;
					next_stk = {return_stack_pointer[7:6], 6'h00}; // RULE7
					next_intc = INTC_RST;
					next_pir = PIR_RST;
					next_lat = LAT_POR;
					next_dir = DIR_RST;
					next_rcs = (cls_cause == C_BROWN_OUT) ? RCS_BOR
						: RCS_POR; // RULE8
				end
				CLS_RST:
				begin
					next_pc = PC_RST;
					next_tos = PC_RST;
					next_stk = 8'h00;
					next_stk[STK_FULL] = (cls_cause == C_STACK_FULL); // RULE8
					next_stk[STK_UNDER] = (cls_cause == C_STACK_UNDER);
					next_intc = {7'h00, interrupt_control_regs[0]}; // RULE7
					next_pir = PIR_RST;
					next_dir = DIR_RST;
					next_rcs[RCS_PRIO_EN] = 1'b0;
					case (cls_cause) // RULE8
						C_PIN_SLEEP:
						begin
							next_rcs[RCS_TO_N] = 1'b1;
							next_rcs[RCS_PD_N] = 1'b0;
						end
						C_WDT_RUN: next_rcs[RCS_TO_N] = 1'b0;
						C_SOFT_RESET: next_rcs[RCS_SOFT_N] = 1'b0;
						C_MONITOR: next_rcs[RCS_MON_N] = 1'b0;
						default: next_rcs[RCS_TO_N] = reset_cause_status[RCS_TO_N];
					endcase
				end
				CLS_WAKE:
				begin
					next_rcs[RCS_PD_N] = 1'b0; // RULE8
					next_pc = pc + PC_STEP; // RULE7
					if (cls_cause == C_WAKE_WDT)
						next_rcs[RCS_TO_N] = 1'b0;
					else
					begin
						// only the waking source flag moves
						next_pir = peripheral_request_flags | src_onehot[7:0]; // RULE4
						next_intc = interrupt_control_regs
							| {4'h0, src_onehot[11:8]}; // RULE4
						if (gie_any)
						begin
							next_tos = pc; // RULE1
							if (return_stack_pointer[4:0] == PTR_MAX)
								next_stk[STK_FULL] = 1'b1;
							else
								next_stk[4:0] = return_stack_pointer[4:0] + 5'h01; // RULE2
							next_pc = cls_high ? VEC_HIGH : VEC_LOW; // RULE3
						end
					end
				end
				default: next_done = 1'b0;
			endcase
		end
		next_lat = next_lat & port_mask; // RULE5
		next_dir = next_dir & port_mask; // RULE5
		next_pin = next_pin & port_mask; // RULE5
		next_stk = next_stk & STK_IMPL; // RULE6
		next_rcs = next_rcs & RCS_IMPL; // RULE6
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			osc_frees <= 1'b0;
			pc <= PC_RST;
			tos <= PC_RST;
			return_stack_pointer <= 8'h00;
			interrupt_control_regs <= INTC_RST;
			peripheral_request_flags <= PIR_RST;
			first_port_input <= 8'h00;
			first_port_latch <= LAT_POR;
			first_port_direction <= DIR_RST & PORT_LOW6;
			reset_cause_status <= RCS_POR;
			init_done <= 1'b0;
		end
		else
		begin
			osc_frees <= next_osc;
			pc <= next_pc;
			tos <= next_tos;
			return_stack_pointer <= next_stk;
			interrupt_control_regs <= next_intc;
			peripheral_request_flags <= next_pir;
			first_port_input <= next_pin;
			first_port_latch <= next_lat;
			first_port_direction <= next_dir;
			reset_cause_status <= next_rcs;
			init_done <= next_done;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);

	sequence s_int_wake;
		cls_valid && cls_class == CLS_WAKE && cls_cause == C_WAKE_INT;
	endsequence

	sequence s_vectored;
		s_int_wake ##0 gie_any;
	endsequence

	a_tos_copy: assert property (s_vectored |=> tos == $past(pc)) // RULE1
		else $error("top of stack did not take the program counter");
	a_stack_advance: assert property ( // RULE2
		s_vectored ##0 return_stack_pointer[4:0] != PTR_MAX
		|=> return_stack_pointer[4:0] == $past(return_stack_pointer[4:0]) + 5'h01)
		else $error("stack pointer did not advance on wake");
	a_vector_load: assert property ( // RULE3
		s_vectored |=> pc == ($past(cls_high) ? VEC_HIGH : VEC_LOW))
		else $error("wrong vector after interrupt wake");
	a_wake_flag: assert property ( // RULE4
		s_int_wake |=> ({interrupt_control_regs[3:0], peripheral_request_flags}
		& $past(src_onehot)) != 12'h000
		&& (peripheral_request_flags & ~$past(src_onehot[7:0]))
		== ($past(peripheral_request_flags) & ~$past(src_onehot[7:0])))
		else $error("wake source flag wrong or other flags moved");
	a_port_mask: assert property ( // RULE5
		!osc_frees |-> ((first_port_latch | first_port_direction
		| first_port_input) & ~PORT_LOW6) == 8'h00)
		else $error("port bits 6 and 7 visible while disabled");
	a_unimpl_zero: assert property ( // RULE6
		(return_stack_pointer & ~STK_IMPL) == 8'h00
		&& (reset_cause_status & ~RCS_IMPL) == 8'h00)
		else $error("unimplemented bit reads one");
	a_wdt_wake_keep: assert property ( // RULE7
		cls_valid && cls_cause == C_WAKE_WDT |=> $stable(first_port_latch)
		&& $stable(tos) && pc == $past(pc) + PC_STEP)
		else $error("watchdog wake changed kept state");
	a_cause_bits: assert property ( // RULE8
		cls_valid && cls_cause == C_WAKE_WDT
		|=> !reset_cause_status[RCS_TO_N] && !reset_cause_status[RCS_PD_N])
		else $error("cause bits not cleared by watchdog wake");
	a_por_image: assert property ( // RULE9
		cls_valid && cls_class == CLS_POR |=> pc == PC_RST
		&& return_stack_pointer[4:0] == 5'h00 && init_done
		&& interrupt_control_regs == INTC_RST ##1 !init_done)
		else $error("power-on image not applied");
	a_apb_one_wait: assert property (psel && penable && !pready
		|=> pready ##1 !pready)
		else $error("apb answer timing wrong");
endmodule
`default_nettype wire
